// *** spp_pkg.sv ***
// Shared constants and helpers of the sixteen-pin parallel port
package spp_pkg;

  // Register offsets from the module base, byte addresses
  localparam logic [11:0] SPP_OFS_FUNC = 12'h004;
  localparam logic [11:0] SPP_OFS_DIR = 12'h244;
  localparam logic [11:0] SPP_OFS_VAL = 12'h248;

  // Register widths and reset values
  localparam int SPP_W = 16;
  localparam logic [15:0] SPP_RST_FUNC = 16'h0000;
  localparam logic [15:0] SPP_RST_DIR = 16'h0000;
  localparam logic [15:0] SPP_RST_VAL = 16'h0000;

  // Field positions of the pin groups
  localparam int SPP_ADDR_LSB = 8;
  localparam int SPP_ACTIVE_BIT = 7;
  localparam int SPP_DMA_REQ_LSB = 5;
  localparam int SPP_MODIFIER_LSB = 2;
  localparam int SPP_KIND_LSB = 0;

  // Low-byte select value that makes pins 7..0 port pins
  localparam logic [15:0] SPP_FUNC_LOW_GPIO = 16'h00ff;

  // Pins that act as port pins for a given function select
  function automatic logic [15:0] spp_gpio_mask(input logic [15:0] func);
    spp_gpio_mask = {~func[15:8], func[7:0]};
  endfunction : spp_gpio_mask

  // Byte-lane merge of a register write
  function automatic logic [15:0] spp_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                            input logic [1:0] be);
    spp_merge = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : spp_merge

endpackage : spp_pkg

// *** spp_alt_signals.sv ***
// Alternate bus and DMA signal generator for the multiplexed port pins
`timescale 1ns/1ps
`default_nettype none
module spp_alt_signals
  import spp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Bus cycle status
  input wire logic bus_start_i,
  input wire logic bus_end_i,
  input wire logic bus_next_i,
  input wire logic bus_granted_i,
  input wire logic [1:0] access_kind_i,
  input wire logic cpu_space_i,
  input wire logic iack_i,
  input wire logic [2:0] iack_level_i,
  input wire logic dma_ack_mode_i,
  input wire logic [1:0] dma_ack_i,
  input wire logic [2:0] modifier_i,
  input wire logic [7:0] addr_hi_i,
  input wire logic addr_drive_i,
  // Alternate pin values
  output logic [15:0] alt_out_o,
  output logic [15:0] alt_oe_o
);

  typedef enum logic [1:0] {SPP_IDLE = 2'b01, SPP_BUSY = 2'b10} spp_xfer_t;

  spp_xfer_t xfer_state;
  logic [2:0] modifier;

  // Transfer tracking; a queued cycle keeps the flag up across the boundary
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      xfer_state <= SPP_IDLE;
    end else if (ce_i) begin
      unique case (xfer_state)
        SPP_IDLE: begin
          if (bus_start_i) xfer_state <= SPP_BUSY;
        end
        SPP_BUSY: begin
          if (bus_end_i && !bus_next_i) xfer_state <= SPP_IDLE;
        end
        default: xfer_state <= SPP_IDLE;
      endcase
    end
  end

  // Modifier code: CPU space wins, then acknowledge level, then DMA acknowledge
  always_comb begin
    if (cpu_space_i) modifier = 3'h0;
    else if (iack_i) modifier = iack_level_i;
    else if (dma_ack_mode_i) modifier = {1'b0, dma_ack_i};
    else modifier = modifier_i;
  end

  // Pin values; the active flag pin is low while a transfer runs
  always_comb begin
    alt_out_o = 16'h0000;
    alt_oe_o = 16'h0000;
    alt_out_o[15:8] = addr_hi_i;
    alt_oe_o[15:8] = {8{addr_drive_i}};
    alt_out_o[SPP_ACTIVE_BIT] = (xfer_state != SPP_BUSY);
    alt_oe_o[SPP_ACTIVE_BIT] = bus_granted_i;
    alt_out_o[4:2] = modifier;
    alt_oe_o[4:2] = {3{bus_granted_i}};
    alt_out_o[1:0] = access_kind_i;
    alt_oe_o[1:0] = {2{bus_granted_i}};
  end

  default clocking spp_cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_active_back_to_back: assert property ((ce_i && xfer_state == SPP_BUSY && bus_end_i
    && bus_next_i) |=> !alt_out_o[SPP_ACTIVE_BIT])
    else $error("transfer flag dropped between back-to-back cycles");
  a_cpu_space_low: assert property (cpu_space_i |-> alt_out_o[4:2] == 3'h0)
    else $error("modifier not low in CPU space");
  a_kind_master_only: assert property (!bus_granted_i |-> alt_oe_o[1:0] == 2'h0)
    else $error("transfer kind driven without bus ownership");

endmodule : spp_alt_signals
`default_nettype wire

// *** spp_parallel_port.sv ***
// Sixteen-pin parallel port: function select, direction and value registers
//
// Summary of operation
// - Upper pins 15..8 are port pins when their select bit is 0 and address lines when 1.
// - Pins 15..10 can be port pins on their own while pins 9..8 stay address lines.
// - Writing 0x00ff to the select register makes pins 7..0 port pins.
// - Pin 7 in its alternate role shows an active transfer and holds across back-to-back cycles.
// - Modifier pins 4..2 are low for CPU-space cycles and carry the level during acknowledges.
// - Kind pins 1..0 are driven only while this device owns the bus and encode the access.
// - A direction bit of 0 makes its pin an input and 1 makes it an output.
// - Direction bits matter only on pins selected as port pins.
// - The value register never touches a pin used in its alternate role.
// - Reading the value register returns the live level of each input port pin.
// - Writing the value register stores input-pin bits without changing those pins.
// - An output port pin reads back its stored bit and is driven with it.
// - Writing an output port pin's bit moves the pin to the new level.
// - The value register takes writes whenever the clock enable is high, whatever the pin settings.
// - Outside bus masters reach these registers just as the processor does.
`timescale 1ns/1ps
`default_nettype none
module spp_parallel_port
  import spp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port, shared by every bus master
  input wire logic reg_sel_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  // Bus cycle status for the alternate pin roles
  input wire logic bus_start_i,
  input wire logic bus_end_i,
  input wire logic bus_next_i,
  input wire logic bus_granted_i,
  input wire logic [1:0] access_kind_i,
  input wire logic cpu_space_i,
  input wire logic iack_i,
  input wire logic [2:0] iack_level_i,
  input wire logic dma_ack_mode_i,
  input wire logic [1:0] dma_ack_i,
  input wire logic [2:0] modifier_i,
  input wire logic [7:0] addr_hi_i,
  input wire logic addr_drive_i,
  // Alternate inputs passed on to the system
  output logic [1:0] dma_request_in_o,
  output logic [7:0] addr_hi_o,
  // Multiplexed pins
  input wire logic [15:0] port_pin_i,
  output logic [15:0] port_pin_o,
  output logic [15:0] port_pin_oe_o
);

  logic [15:0] pin_function_select;
  logic [15:0] port_direction;
  logic [15:0] port_value;
  logic [15:0] gpio_mask;
  logic [15:0] alt_out;
  logic [15:0] alt_oe;
  logic [15:0] next_pin;
  logic [15:0] next_oe;
  logic [15:0] next_rdata;
  logic hit_func;
  logic hit_dir;
  logic hit_val;
  logic access;

  // Alternate bus signal source
  spp_alt_signals u_alt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .bus_start_i(bus_start_i),
    .bus_end_i(bus_end_i),
    .bus_next_i(bus_next_i),
    .bus_granted_i(bus_granted_i),
    .access_kind_i(access_kind_i),
    .cpu_space_i(cpu_space_i),
    .iack_i(iack_i),
    .iack_level_i(iack_level_i),
    .dma_ack_mode_i(dma_ack_mode_i),
    .dma_ack_i(dma_ack_i),
    .modifier_i(modifier_i),
    .addr_hi_i(addr_hi_i),
    .addr_drive_i(addr_drive_i),
    .alt_out_o(alt_out),
    .alt_oe_o(alt_oe)
  );

  // Address decode; no master identity is checked, so outside masters reach it too
  assign access = reg_sel_i && (reg_wr_i || reg_rd_i);
  assign hit_func = (reg_addr_i == SPP_OFS_FUNC);
  assign hit_dir = (reg_addr_i == SPP_OFS_DIR);
  assign hit_val = (reg_addr_i == SPP_OFS_VAL);

  // Port-pin mask; each select bit acts alone, so 15..10 split from 9..8 freely
  assign gpio_mask = spp_gpio_mask(pin_function_select);

  // Function select register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pin_function_select <= SPP_RST_FUNC;
    end else if (ce_i && reg_sel_i && reg_wr_i && hit_func) begin
      pin_function_select <= spp_merge(pin_function_select, reg_wdata_i, reg_be_i);
    end
  end

  // Direction register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      port_direction <= SPP_RST_DIR;
    end else if (ce_i && reg_sel_i && reg_wr_i && hit_dir) begin
      port_direction <= spp_merge(port_direction, reg_wdata_i, reg_be_i);
    end
  end

  // Value register; stored for every pin, whatever its role or direction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      port_value <= SPP_RST_VAL;
    end else if (ce_i && reg_sel_i && reg_wr_i && hit_val) begin
      port_value <= spp_merge(port_value, reg_wdata_i, reg_be_i);
    end
  end

  // Read data: input port pins show the live level, all else the stored bits
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_func) begin
      next_rdata = pin_function_select;
    end else if (hit_dir) begin
      next_rdata = port_direction;
    end else if (hit_val) begin
      next_rdata = (port_pin_i & gpio_mask & ~port_direction)
        | (port_value & ~(gpio_mask & ~port_direction));
    end
  end

  // Register answer, one cycle after the request; unmapped offsets flag an error
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else if (ce_i) begin
      reg_ack_o <= access && (hit_func || hit_dir || hit_val);
      reg_err_o <= access && !(hit_func || hit_dir || hit_val);
      reg_rdata_o <= (access && reg_rd_i) ? next_rdata : 16'h0000;
    end
  end

  // Pin mux: port pins follow direction and value, the rest their alternate role
  always_comb begin
    next_oe = (gpio_mask & port_direction) | (~gpio_mask & alt_oe);
    next_pin = (gpio_mask & port_direction & port_value)
      | (~gpio_mask & alt_out);
  end

  // Pins are registered so the outputs never glitch on a register write
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      port_pin_o <= 16'h0000;
      port_pin_oe_o <= 16'h0000;
    end else if (ce_i) begin
      port_pin_o <= next_pin;
      port_pin_oe_o <= next_oe;
    end
  end

  // DMA requests come in on pins 6..5 only while they are in their alternate role
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dma_request_in_o <= 2'h0;
    end else if (ce_i) begin
      dma_request_in_o <= port_pin_i[6:5] & ~gpio_mask[6:5];
    end
  end

  // Upper address from an outside master, taken while this device does not drive
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      addr_hi_o <= 8'h00;
    end else if (ce_i) begin
      addr_hi_o <= addr_drive_i ? 8'h00 : (port_pin_i[15:8] & ~gpio_mask[15:8]);
    end
  end

  default clocking spp_cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_upper_select_map: assert property (ce_i |=> ((port_pin_oe_o[15:8]
    & $past(pin_function_select[15:8])) == ($past(alt_oe[15:8])
    & $past(pin_function_select[15:8]))))
    else $error("address pin enable not from the alternate source");

  a_split_upper: assert property (gpio_mask[15:10] == ~pin_function_select[15:10])
    else $error("pins 15..10 not set on their own");

  a_low_gpio_write: assert property ((ce_i && reg_sel_i && reg_wr_i && hit_func
    && reg_be_i == 2'h3 && reg_wdata_i == SPP_FUNC_LOW_GPIO) |=> gpio_mask[7:0] == 8'hff)
    else $error("low pins not port pins after select write");

  a_dir_enables: assert property (ce_i |=> ((port_pin_oe_o & $past(gpio_mask))
    == ($past(port_direction) & $past(gpio_mask))))
    else $error("port pin enable does not follow direction");

  a_dir_ignored: assert property ((ce_i && rst_n_i) ##1 (ce_i && $changed(port_direction)
    && $stable(alt_oe) && $stable(pin_function_select)) |=> ((port_pin_oe_o
    & ~$past(gpio_mask)) == ($past(port_pin_oe_o) & ~$past(gpio_mask))))
    else $error("direction change moved an alternate pin");

  a_value_isolated: assert property ((ce_i && rst_n_i) |=> ((port_pin_o
    & ~$past(gpio_mask)) == ($past(alt_out) & ~$past(gpio_mask))))
    else $error("value register reached an alternate pin");

  a_input_readback: assert property ((ce_i && reg_sel_i && reg_rd_i && hit_val)
    |=> ((reg_rdata_o & $past(gpio_mask) & ~$past(port_direction))
    == ($past(port_pin_i) & $past(gpio_mask) & ~$past(port_direction))))
    else $error("input pin level not returned on read");

  a_input_undriven: assert property ((ce_i && reg_sel_i && reg_wr_i && hit_val)
    |=> ((port_pin_oe_o & $past(gpio_mask) & ~$past(port_direction)) == 16'h0000))
    else $error("write drove an input pin");

  a_output_readback: assert property ((ce_i && reg_sel_i && reg_rd_i && hit_val)
    |=> ((reg_rdata_o & $past(gpio_mask) & $past(port_direction))
    == ($past(port_value) & $past(gpio_mask) & $past(port_direction))))
    else $error("output pin read not from register");

  a_output_follows: assert property ((ce_i && reg_sel_i && reg_wr_i && hit_val
    && reg_be_i == 2'h3) ##1 ce_i |=> ((port_pin_o & $past(gpio_mask) & $past(port_direction))
    == ($past(reg_wdata_i, 2) & $past(gpio_mask) & $past(port_direction))))
    else $error("output pin did not follow written bit");

  a_value_any_time: assert property ((ce_i && reg_sel_i && reg_wr_i && hit_val
    && reg_be_i == 2'h3) |=> port_value == $past(reg_wdata_i))
    else $error("value write lost");

  a_shared_access: assert property ((ce_i && access && hit_val) |=> reg_ack_o && !reg_err_o)
    else $error("mapped access not answered");

  // Register answers and lane-wise writes
  a_unmapped_error: assert property ((ce_i && rst_n_i && access
    && !(hit_func || hit_dir || hit_val)) |=> reg_err_o && !reg_ack_o)
    else $error("unmapped access not flagged");

  a_unmapped_zero: assert property ((ce_i && rst_n_i && access && reg_rd_i
    && !(hit_func || hit_dir || hit_val)) |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read returned data");

  a_no_request_quiet: assert property ((ce_i && rst_n_i && !access)
    |=> !reg_ack_o && !reg_err_o)
    else $error("answer without a request");

  a_read_idle_zero: assert property ((ce_i && rst_n_i && !(access && reg_rd_i))
    |=> reg_rdata_o == 16'h0000)
    else $error("read data outside a read");

  a_func_write: assert property ((ce_i && rst_n_i && reg_sel_i && reg_wr_i && hit_func
    && reg_be_i == 2'h3) |=> pin_function_select == $past(reg_wdata_i))
    else $error("select write lost");

  a_dir_write: assert property ((ce_i && rst_n_i && reg_sel_i && reg_wr_i && hit_dir
    && reg_be_i == 2'h3) |=> port_direction == $past(reg_wdata_i))
    else $error("direction write lost");

  a_upper_lane_kept: assert property ((ce_i && rst_n_i && reg_sel_i && reg_wr_i && hit_val
    && reg_be_i == 2'h1) |=> port_value[15:8] == $past(port_value[15:8]))
    else $error("upper value byte changed without its lane");

  // Clock enable low freezes every register, pin and answer
  a_freeze_regs: assert property ((!ce_i && rst_n_i) |=> $stable(port_value)
    && $stable(port_direction) && $stable(pin_function_select))
    else $error("register moved while frozen");

  a_freeze_pins: assert property ((!ce_i && rst_n_i) |=> $stable(port_pin_o)
    && $stable(port_pin_oe_o))
    else $error("pin moved while frozen");

  a_freeze_answer: assert property ((!ce_i && rst_n_i) |=> $stable(reg_ack_o)
    && $stable(reg_rdata_o) && $stable(reg_err_o))
    else $error("answer moved while frozen");

  // Alternate roles; a pin left as a port pin must not see any of these
  a_dma_never_driven: assert property ((ce_i && rst_n_i) |=> (port_pin_oe_o[6:5]
    & ~$past(gpio_mask[6:5])) == 2'h0)
    else $error("request pin driven in its alternate role");

  a_dma_request_pass: assert property ((ce_i && rst_n_i) |=> dma_request_in_o
    == ($past(port_pin_i[6:5]) & ~$past(gpio_mask[6:5])))
    else $error("request not passed on");

  a_addr_capture: assert property ((ce_i && rst_n_i && !addr_drive_i) |=> addr_hi_o
    == ($past(port_pin_i[15:8]) & ~$past(gpio_mask[15:8])))
    else $error("outside address not taken");

  a_addr_quiet: assert property ((ce_i && rst_n_i && addr_drive_i)
    |=> addr_hi_o == 8'h00)
    else $error("address taken while driving");

  a_addr_driven: assert property ((ce_i && rst_n_i && addr_drive_i) |=> ((port_pin_o[15:8]
    & ~$past(gpio_mask[15:8])) == ($past(addr_hi_i) & ~$past(gpio_mask[15:8]))))
    else $error("address pins not driven with the address");

  a_kind_follows: assert property ((ce_i && rst_n_i && bus_granted_i
    && pin_function_select[1:0] == 2'h0) |=> port_pin_o[1:0] == $past(access_kind_i)
    && port_pin_oe_o[1:0] == 2'h3)
    else $error("transfer kind not on its pins");

  a_kind_released: assert property ((ce_i && rst_n_i && !bus_granted_i
    && pin_function_select[1:0] == 2'h0) |=> port_pin_oe_o[1:0] == 2'h0)
    else $error("kind pins driven without the bus");

  a_cpu_pins_low: assert property ((ce_i && rst_n_i && cpu_space_i
    && pin_function_select[4:2] == 3'h0) |=> port_pin_o[4:2] == 3'h0)
    else $error("modifier pins not low in CPU space");

  a_iack_level: assert property ((ce_i && rst_n_i && iack_i && !cpu_space_i
    && pin_function_select[4:2] == 3'h0) |=> port_pin_o[4:2] == $past(iack_level_i))
    else $error("acknowledged level not on modifier pins");

  a_flag_enable: assert property ((ce_i && rst_n_i && !pin_function_select[SPP_ACTIVE_BIT])
    |=> port_pin_oe_o[SPP_ACTIVE_BIT] == $past(bus_granted_i))
    else $error("transfer flag enable not from bus ownership");

  a_input_pin_low: assert property ((ce_i && rst_n_i) |=> ((port_pin_o
    & $past(gpio_mask) & ~$past(port_direction)) == 16'h0000))
    else $error("input port pin carries a value");

  a_output_level: assert property ((ce_i && rst_n_i) |=> ((port_pin_o & $past(gpio_mask)
    & $past(port_direction)) == ($past(port_value) & $past(gpio_mask) & $past(port_direction))))
    else $error("output pin level not the stored bit");

endmodule : spp_parallel_port
`default_nettype wire

// *** spp_board_model.sv ***
// Board-side model of the logic that sits on the general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module spp_board_model (
  // Device pins
  input wire logic [15:0] pin_o_i,
  input wire logic [15:0] pin_oe_i,
  // Board levels and DMA requests
  input wire logic [15:0] ext_i,
  input wire logic [1:0] dma_req_i,
  output logic [15:0] pin_level_o
);
  // The board yields wherever the device drives, so no pin ever fights
  always_comb begin
    pin_level_o = ext_i;
    pin_level_o[6:5] = dma_req_i;
    pin_level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & pin_level_o);
  end
endmodule : spp_board_model
`default_nettype wire

// *** spp_parallel_port_tb.sv ***
// Self-checking bench of the sixteen-pin parallel port
`timescale 1ns/1ps
`default_nettype none
module spp_parallel_port_tb;
  import spp_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sel = 1'b0, wr = 1'b0, rd = 1'b0, ack, err;
  logic bstart = 1'b0, bend = 1'b0, bnext = 1'b0, grant = 1'b0, cpu = 1'b0, iack = 1'b0;
  logic ack_mode = 1'b0, adrv = 1'b0;
  logic [1:0] be = 2'h3, kind = 2'h0, ack_bits = 2'h0, dma_req = 2'h2, dma_req_o;
  logic [2:0] lvl = 3'h0, modf = 3'h0;
  logic [7:0] ahi = 8'h96, ahi_o;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000, rdata, rq, ext = 16'h5a3c, pin_i, pin_o, pin_oe;
  int errors = 0, checks_done = 0;

  spp_parallel_port dut (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_sel_i(sel),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_be_i(be), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_err_o(err), .bus_start_i(bstart),
    .bus_end_i(bend), .bus_next_i(bnext), .bus_granted_i(grant), .access_kind_i(kind),
    .cpu_space_i(cpu), .iack_i(iack), .iack_level_i(lvl), .dma_ack_mode_i(ack_mode),
    .dma_ack_i(ack_bits), .modifier_i(modf), .addr_hi_i(ahi), .addr_drive_i(adrv),
    .dma_request_in_o(dma_req_o), .addr_hi_o(ahi_o), .port_pin_i(pin_i),
    .port_pin_o(pin_o), .port_pin_oe_o(pin_oe));

  spp_board_model board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext),
    .dma_req_i(dma_req), .pin_level_o(pin_i));

  // 200 MHz system clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One access; strobes drop after the taking edge, answer is sampled after it
  task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic e);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    sel <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    rq = rdata;
    chk({14'h0000, err, ack}, {14'h0000, e, ~e});
  endtask : acc

  // Pins follow one cycle after the cause is taken
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wait_flag(input logic v);
    int n;
    n = 0;
    #1;
    while (pin_o[7] !== v && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({15'h0000, pin_o[7]}, {15'h0000, v});
  endtask : wait_flag

  task automatic t_reset;
    acc(1'b0, SPP_OFS_FUNC, 16'h0000, 1'b0);
    chk(rq, SPP_RST_FUNC);
    acc(1'b0, SPP_OFS_DIR, 16'h0000, 1'b0);
    chk(rq, SPP_RST_DIR);
    acc(1'b0, SPP_OFS_VAL, 16'h0000, 1'b0);
    chk(rq, {ext[15:8], 8'h00});
    chk(pin_oe, 16'h0000);
    acc(1'b0, 12'h100, 16'h0000, 1'b1);
    chk(rq, 16'h0000);
  endtask : t_reset

  task automatic t_low;
    acc(1'b1, SPP_OFS_FUNC, SPP_FUNC_LOW_GPIO, 1'b0);
    acc(1'b1, SPP_OFS_DIR, 16'h00f0, 1'b0);
    acc(1'b1, SPP_OFS_VAL, 16'h00a0, 1'b0);
    settle;
    chk(pin_oe, 16'h00f0);
    chk(pin_o & 16'h00f0, 16'h00a0);
    acc(1'b0, SPP_OFS_VAL, 16'h0000, 1'b0);
    chk(rq, 16'h5aac);
    acc(1'b1, SPP_OFS_VAL, 16'hff0f, 1'b0);
    settle;
    chk(pin_oe, 16'h00f0);
    chk(pin_o & 16'h00f0, 16'h0000);
    acc(1'b0, SPP_OFS_VAL, 16'h0000, 1'b0);
    chk(rq, 16'h5a0c);
  endtask : t_low

  task automatic t_upper;
    @(posedge clk);
    adrv <= 1'b1;
    acc(1'b1, SPP_OFS_FUNC, 16'h03ff, 1'b0);
    acc(1'b1, SPP_OFS_DIR, 16'hfff0, 1'b0);
    acc(1'b1, SPP_OFS_VAL, 16'ha7a0, 1'b0);
    settle;
    chk(pin_oe, 16'hfff0);
    chk(pin_o & 16'hff00, 16'ha600);
    @(posedge clk);
    adrv <= 1'b0;
    settle;
    chk({8'h00, ahi_o}, 16'h0002);
    acc(1'b1, SPP_OFS_FUNC, 16'hff00, 1'b0);
    settle;
    chk(pin_oe, 16'h0000);
    chk({8'h00, ahi_o}, {8'h00, ext[15:8]});
  endtask : t_upper

  task automatic t_alt;
    acc(1'b1, SPP_OFS_VAL, 16'hffff, 1'b0);
    settle;
    chk({14'h0000, dma_req_o}, 16'h0002);
    @(posedge clk);
    grant <= 1'b1;
    cpu <= 1'b1;
    settle;
    chk(pin_oe & 16'h00ff, 16'h009f);
    chk(pin_o & 16'h009c, 16'h0080);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      kind <= k[1:0];
      settle;
      chk({14'h0000, pin_o[1:0]}, k[15:0]);
    end
    @(posedge clk);
    cpu <= 1'b0;
    iack <= 1'b1;
    lvl <= 3'h5;
    settle;
    chk({13'h0000, pin_o[4:2]}, 16'h0005);
    @(posedge clk);
    iack <= 1'b0;
    ack_mode <= 1'b1;
    ack_bits <= 2'h3;
    settle;
    chk({13'h0000, pin_o[4:2]}, 16'h0003);
    @(posedge clk);
    ack_mode <= 1'b0;
    modf <= 3'h6;
    settle;
    chk({13'h0000, pin_o[4:2]}, 16'h0006);
  endtask : t_alt

  // Back-to-back cycles must not let the transfer flag blink idle
  task automatic t_flag;
    @(posedge clk);
    bstart <= 1'b1;
    @(posedge clk);
    bstart <= 1'b0;
    wait_flag(1'b0);
    @(posedge clk);
    bend <= 1'b1;
    bnext <= 1'b1;
    @(posedge clk);
    bend <= 1'b0;
    bnext <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      chk({15'h0000, pin_o[7]}, 16'h0000);
    end
    @(posedge clk);
    bend <= 1'b1;
    @(posedge clk);
    bend <= 1'b0;
    wait_flag(1'b1);
  endtask : t_flag

  // Value written while the pins were alternate shows once they are port pins
  task automatic t_any;
    acc(1'b1, SPP_OFS_FUNC, SPP_FUNC_LOW_GPIO, 1'b0);
    settle;
    chk(pin_o & 16'h00f0, 16'h00f0);
  endtask : t_any

  // A write held while the enable is low lands once it rises, lower lane only
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    sel <= 1'b1;
    wr <= 1'b1;
    addr <= SPP_OFS_VAL;
    wdata <= 16'h0000;
    be <= 2'h1;
    settle;
    chk({15'h0000, ack}, 16'h0000);
    chk(pin_o & 16'hfff0, 16'hfff0);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    sel <= 1'b0;
    wr <= 1'b0;
    be <= 2'h3;
    #1;
    chk({15'h0000, ack}, 16'h0001);
    settle;
    chk(pin_o & 16'hfff0, 16'hff00);
  endtask : t_freeze

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_low;
    t_upper;
    t_alt;
    t_flag;
    t_any;
    t_freeze;
    tally_and_finish;
  end

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    errors++;
    tally_and_finish;
  end
endmodule : spp_parallel_port_tb
`default_nettype wire
